// File: hw/opc_params.svh
`ifndef OPC_PARAMS_SVH
`define OPC_PARAMS_SVH

// Register offsets.
`define OPC_ADDR_PORT 8'h25
`define OPC_ADDR_TRI 8'h26
`define OPC_ADDR_LPWR 8'h27

// Reset values of the three registers.
`define OPC_RST_PORT 8'h72
`define OPC_RST_TRI 8'h08
`define OPC_RST_LPWR 8'h80

// Field positions, output port register.
`define OPC_MODE_HI 3
`define OPC_MODE_LO 2
`define OPC_PRI_EN 1
`define OPC_SEC_EN 0

// Field positions, three-state and power-down register.
`define OPC_TRI_VIDEO 7
`define OPC_TRI_SOG 6
`define OPC_TRI_SPDIF 5
`define OPC_TRI_I2S 4
`define OPC_PD_POL 3
`define OPC_PD_FN_HI 2
`define OPC_PD_FN_LO 1
`define OPC_PD_FORCE 0

// Field positions, low-power and audio clock register.
`define OPC_AUTO_LP 7
`define OPC_PROT_LSB 6
`define OPC_MCLK_EXT 5
`define OPC_TIMING_CODE 4

// Field encodings.
`define OPC_MODE_12B422 2'h3
`define OPC_MODE_DDR1 2'h1
`define OPC_MODE_DDR2 2'h2
`define OPC_PD_FN_PD 2'h0
`define OPC_PD_FN_PD_SOG 2'h1
`define OPC_PD_FN_FLOAT 2'h2
`define OPC_PD_FN_FLOAT_SOG 2'h3

// Serial bus device address, value arbitrary.
`define OPC_DEV_ADDR 7'h4c

// Audio sample slip window: occupancy limit and start point.
`define OPC_SLIP_MAX 2'h3
`define OPC_SLIP_MID 2'h2

`endif

// File: hw/opc_pkg.sv
package opc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_SUB,
    ST_WDATA,
    ST_RDATA,
    ST_MACK,
    ST_RLOAD
  } cfg_state_e;

endpackage

// File: hw/cfg_serial_slave.sv
`timescale 1ns/100ps
`include "opc_params.svh"

module cfg_serial_slave (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] rd_data,
  output logic sda_oe,
  output logic wr_stb,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage 1 feeds stage 2 only, stage 3 is the edge history.
  logic [2:0] scl_q, scl_d;
  logic [2:0] sda_q, sda_d;
  logic start_c, stop_c, rise_c, fall_c;

  always_comb begin
    scl_d = {scl_q[1:0], scl_in};
    sda_d = {sda_q[1:0], sda_in};
    start_c = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    stop_c = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    rise_c = scl_q[1] & ~scl_q[2];
    fall_c = ~scl_q[1] & scl_q[2];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine: address, register pointer, then data with auto-increment.
  opc_pkg::cfg_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d, ptr_q, ptr_d, wdat_q, wdat_d;
  logic rw_q, rw_d, sub_q, sub_d, oe_q, oe_d, wr_q, wr_d;
  logic wr_hold_q, wr_hold_d;
  logic [7:0] in_byte;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    wdat_d = wdat_q;
    rw_d = rw_q;
    sub_d = sub_q;
    oe_d = oe_q;
    wr_d = 1'b0;
    in_byte = {shift_q[6:0], sda_q[1]};
    if (start_c) begin
      state_d = opc_pkg::ST_ADDR;
      cnt_d = 3'h0;
      sub_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      state_d = opc_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        opc_pkg::ST_ADDR, opc_pkg::ST_SUB, opc_pkg::ST_WDATA: begin
          if (rise_c) begin
            shift_d = in_byte;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              state_d = opc_pkg::ST_ACK;
              if (state_q == opc_pkg::ST_ADDR) begin
                rw_d = in_byte[0];
                if (in_byte[7:1] != `OPC_DEV_ADDR) begin
                  state_d = opc_pkg::ST_IDLE;
                end
              end else if (state_q == opc_pkg::ST_SUB) begin
                ptr_d = in_byte;
                sub_d = 1'b1;
              end else begin
                wdat_d = in_byte;
                wr_d = 1'b1;
              end
            end
          end
        end
        opc_pkg::ST_ACK: begin
          if (fall_c) begin
            if (!oe_q) begin
              oe_d = 1'b1;
            end else if (rw_q) begin
              shift_d = rd_data;
              oe_d = ~rd_data[7];
              cnt_d = 3'h0;
              state_d = opc_pkg::ST_RDATA;
            end else begin
              oe_d = 1'b0;
              cnt_d = 3'h0;
              if (wr_hold_q) begin
                ptr_d = ptr_q + 8'h01;
              end
              state_d = sub_q ? opc_pkg::ST_WDATA : opc_pkg::ST_SUB;
            end
          end
        end
        opc_pkg::ST_RDATA: begin
          if (fall_c) begin
            shift_d = {shift_q[6:0], 1'b0};
            oe_d = ~shift_q[6];
          end else if (rise_c) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              ptr_d = ptr_q + 8'h01;
              state_d = opc_pkg::ST_MACK;
            end
          end
        end
        opc_pkg::ST_MACK: begin
          if (fall_c) begin
            oe_d = 1'b0;
          end else if (rise_c) begin
            state_d = sda_q[1] ? opc_pkg::ST_IDLE : opc_pkg::ST_RLOAD;
          end
        end
        opc_pkg::ST_RLOAD: begin
          if (fall_c) begin
            shift_d = rd_data;
            oe_d = ~rd_data[7];
            cnt_d = 3'h0;
            state_d = opc_pkg::ST_RDATA;
          end
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // The write pulse lasts one cycle, so the pointer advance in the ack phase
  // keys on the registered write flag held until the ack ends.

  always_comb begin
    wr_hold_d = wr_hold_q;
    if (wr_d) begin
      wr_hold_d = 1'b1;
    end else if (state_q == opc_pkg::ST_ACK && state_d != opc_pkg::ST_ACK) begin
      wr_hold_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= opc_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      wdat_q <= 8'h00;
      rw_q <= 1'b0;
      sub_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      wr_hold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      wdat_q <= wdat_d;
      rw_q <= rw_d;
      sub_q <= sub_d;
      oe_q <= oe_d;
      wr_q <= wr_d;
      wr_hold_q <= wr_hold_d;
    end
  end

  assign sda_oe = oe_q;
  assign wr_stb = wr_q;
  assign reg_addr = ptr_q;
  assign wr_data = wdat_q;

endmodule // cfg_serial_slave

// File: hw/output_power_control_regs.sv
// Overview of operation
// [R01] Output mode 11 drives 12-bit 4:2:2 video.
// [R02] Primary output enable default on; secondary off.
// [R03] Bits 7..4 float video, sync, audio outputs.
// [R04] Bit 3 sets power-down pin active level.
// [R05] Pin function field; bit 0 forces power-down.
// [R06] Bit 7 enables automatic low-power state, default set.
// [R07] Bit 6 gives protection serial address LSB.
// [R08] Host sets that LSB only for second receiver.
// [R09] Bit 5 selects external audio master clock.
// [R10] External master clock must track video clock.
// [R11] Clock mismatch drops or repeats audio samples.
// [R12] Bit 4 embeds active video timing codes.
// [R13] Defaults at reset; writes act at once.
`timescale 1ns/100ps
`include "opc_params.svh"

module output_power_control_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pd_pin,
  input wire logic int_mclk_tick,
  input wire logic ext_mclk_pin,
  output logic [1:0] video_mode,
  output logic video_12b_422,
  output logic primary_out_en,
  output logic secondary_out_en,
  output logic video_oe,
  output logic green_channel_sync_out_oe,
  output logic spdif_oe,
  output logic i2s_mclk_oe,
  output logic power_down,
  output logic auto_low_power_en,
  output logic protection_addr_lsb,
  output logic mclk_ext_sel,
  output logic embedded_timing_code_enable,
  output logic sample_drop,
  output logic sample_repeat
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial configuration access.
  logic slv_oe, wr_stb;
  logic [7:0] reg_addr, wr_data, rd_data;

  cfg_serial_slave u_slave (
    .clk(ref_clk),
    .arst_n(arst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .rd_data(rd_data),
    .sda_oe(slv_oe),
    .wr_stb(wr_stb),
    .reg_addr(reg_addr),
    .wr_data(wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register bank.
  logic [7:0] port_q, port_d, tri_q, tri_d, lpwr_q, lpwr_d;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] p,
                                          input logic [7:0] t, input logic [7:0] l);
    case (a)
      `OPC_ADDR_PORT: read_mux = p;
      `OPC_ADDR_TRI: read_mux = t;
      `OPC_ADDR_LPWR: read_mux = l;
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    port_d = port_q;
    tri_d = tri_q;
    lpwr_d = lpwr_q;
    if (wr_stb) begin
      case (reg_addr)
        `OPC_ADDR_PORT: port_d = wr_data; // R13
        `OPC_ADDR_TRI: tri_d = wr_data; // R13
        `OPC_ADDR_LPWR: lpwr_d = wr_data; // R13
        default: begin
        end
      endcase
    end
    rd_data = read_mux(reg_addr, port_q, tri_q, lpwr_q);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_q <= `OPC_RST_PORT; // R13
      tri_q <= `OPC_RST_TRI; // R13
      lpwr_q <= `OPC_RST_LPWR; // R13
    end else begin
      port_q <= port_d;
      tri_q <= tri_d;
      lpwr_q <= lpwr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down pin, synchronised before use.
  logic [1:0] pd_sync_q, pd_sync_d;
  logic pd_active;
  logic [1:0] pd_fn;

  // True when the pin function asks for a real power-down.
  function automatic logic fn_powers_down(input logic [1:0] fn);
    fn_powers_down = (fn == `OPC_PD_FN_PD) || (fn == `OPC_PD_FN_PD_SOG);
  endfunction

  // True when the pin function floats the green-channel sync output.
  function automatic logic fn_floats_sog(input logic [1:0] fn);
    fn_floats_sog = (fn == `OPC_PD_FN_PD_SOG) || (fn == `OPC_PD_FN_FLOAT_SOG);
  endfunction

  always_comb begin
    pd_sync_d = {pd_sync_q[0], pd_pin};
    pd_active = pd_sync_q[1] ~^ tri_q[`OPC_PD_POL]; // R04
    pd_fn = tri_q[`OPC_PD_FN_HI:`OPC_PD_FN_LO];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs derived from the bank.
  logic [13:0] out_q, out_d;
  logic [1:0] mode;
  logic pin_float;

  always_comb begin
    mode = port_q[`OPC_MODE_HI:`OPC_MODE_LO];
    // Functions 10 and 11 float the video and audio outputs without powering down.
    pin_float = pd_active && !fn_powers_down(pd_fn); // R05
    out_d[1:0] = mode;
    out_d[2] = (mode == `OPC_MODE_12B422); // R01
    out_d[3] = port_q[`OPC_PRI_EN]; // R02
    // Secondary port carries data only in the two DDR 4:2:2 modes.
    out_d[4] = port_q[`OPC_SEC_EN] &&
               ((mode == `OPC_MODE_DDR1) || (mode == `OPC_MODE_DDR2)); // R02
    out_d[5] = !tri_q[`OPC_TRI_VIDEO] && !pin_float; // R03
    out_d[6] = !tri_q[`OPC_TRI_SOG] && !(pd_active && fn_floats_sog(pd_fn)); // R03
    out_d[7] = !tri_q[`OPC_TRI_SPDIF] && !pin_float; // R03
    out_d[8] = !tri_q[`OPC_TRI_I2S] && !pin_float; // R03
    out_d[9] = tri_q[`OPC_PD_FORCE] || (pd_active && fn_powers_down(pd_fn)); // R05
    out_d[10] = lpwr_q[`OPC_AUTO_LP]; // R06
    out_d[11] = lpwr_q[`OPC_PROT_LSB]; // R07
    out_d[12] = lpwr_q[`OPC_MCLK_EXT]; // R09
    out_d[13] = lpwr_q[`OPC_TIMING_CODE]; // R12
  end

  ////////////////////////////////////////////////////////////////////////////
  // Audio sample slip. Samples arrive at the internal rate and leave at the
  // selected master clock rate; a small occupancy count absorbs jitter and
  // any lasting mismatch becomes a dropped or repeated sample rather than a
  // corrupted stream. With the internal clock selected both rates match.
  logic [2:0] mck_q, mck_d;
  logic [1:0] occ_q, occ_d;
  logic drop_q, drop_d, rep_q, rep_d;
  logic take;

  always_comb begin
    mck_d = {mck_q[1:0], ext_mclk_pin};
    take = out_q[12] ? (mck_q[1] & ~mck_q[2]) : int_mclk_tick; // R09
    occ_d = occ_q;
    drop_d = 1'b0;
    rep_d = 1'b0;
    if (int_mclk_tick && !take) begin
      if (occ_q == `OPC_SLIP_MAX) begin
        drop_d = 1'b1; // R11
      end else begin
        occ_d = occ_q + 2'h1;
      end
    end else if (take && !int_mclk_tick) begin
      if (occ_q == 2'h0) begin
        rep_d = 1'b1; // R11
      end else begin
        occ_d = occ_q - 2'h1;
      end
    end
    if (out_q[12] != out_d[12]) begin
      occ_d = `OPC_SLIP_MID;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_sync_q <= 2'h0;
      out_q <= 14'h0000;
      mck_q <= 3'h0;
      occ_q <= `OPC_SLIP_MID;
      drop_q <= 1'b0;
      rep_q <= 1'b0;
    end else begin
      pd_sync_q <= pd_sync_d;
      out_q <= out_d;
      mck_q <= mck_d;
      occ_q <= occ_d;
      drop_q <= drop_d;
      rep_q <= rep_d;
    end
  end

  // The line is open drain: the data level is always low, the enable pulls.
  assign sda_out = 1'b0;
  assign sda_oe = slv_oe;
  assign video_mode = out_q[1:0];
  assign video_12b_422 = out_q[2];
  assign primary_out_en = out_q[3];
  assign secondary_out_en = out_q[4];
  assign video_oe = out_q[5];
  assign green_channel_sync_out_oe = out_q[6];
  assign spdif_oe = out_q[7];
  assign i2s_mclk_oe = out_q[8];
  assign power_down = out_q[9];
  assign auto_low_power_en = out_q[10];
  assign protection_addr_lsb = out_q[11];
  assign mclk_ext_sel = out_q[12];
  assign embedded_timing_code_enable = out_q[13];
  assign sample_drop = drop_q;
  assign sample_repeat = rep_q;

endmodule // output_power_control_regs

// File: testbench/opc_props.sv
`timescale 1ns/100ps
module opc_props (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic pd_pin,
  input wire logic int_mclk_tick,
  input wire logic ext_mclk_pin,
  input wire logic [1:0] video_mode,
  input wire logic video_12b_422,
  input wire logic primary_out_en,
  input wire logic secondary_out_en,
  input wire logic video_oe,
  input wire logic green_channel_sync_out_oe,
  input wire logic spdif_oe,
  input wire logic i2s_mclk_oe,
  input wire logic power_down,
  input wire logic auto_low_power_en,
  input wire logic protection_addr_lsb,
  input wire logic mclk_ext_sel,
  input wire logic embedded_timing_code_enable,
  input wire logic sample_drop,
  input wire logic sample_repeat
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire [4:0] pin_outs = {power_down, video_oe, green_channel_sync_out_oe, spdif_oe, i2s_mclk_oe};
  wire [6:0] cfg = {auto_low_power_en, protection_addr_lsb, mclk_ext_sel,
    embedded_timing_code_enable, primary_out_en, video_mode};
  ////////////////////////////////////////
  a_mode_decode: assert property (video_12b_422 == (video_mode == 2'h3))
    else $error("mode flag mismatch");
  a_sec_gate: assert property (secondary_out_en |-> video_mode inside {2'h1, 2'h2})
    else $error("secondary output outside modes 1 and 2");
  a_reset_defaults: assert property ($rose(arst_n) |-> ##1 (primary_out_en &&
    !secondary_out_en && video_mode == 2'h0 && auto_low_power_en && !protection_addr_lsb &&
    !mclk_ext_sel && !embedded_timing_code_enable && !power_down))
    else $error("defaults wrong after reset");
  // Register writes land while the bus clock is still high, so any other change is spurious.
  a_cfg_write: assert property ($changed(cfg) |-> scl_in)
    else $error("configuration changed outside a write");
  a_sda_change: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  a_pin_latency: assert property ($changed(pd_pin) |-> ##[2:5] $changed(pin_outs))
    else $error("pin had no effect in time");
  a_sda_open_drain: assert property (!sda_out)
    else $error("data line driven high");
  a_slip_excl: assert property (!(sample_drop && sample_repeat))
    else $error("drop and repeat together");
  a_drop_cause: assert property (sample_drop |-> $past(int_mclk_tick) ||
    $past(int_mclk_tick, 2))
    else $error("drop without source tick");
  c_mode: cover property (video_12b_422);
  c_pd: cover property (power_down);
  c_drop: cover property (sample_drop);
  c_rep: cover property (sample_repeat);
endmodule // opc_props

bind output_power_control_regs opc_props chk (.*);

// File: testbench/cfg_host.sv
`timescale 1ns/100ps
`include "opc_params.svh"
module cfg_host (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Ten cycles a phase keeps well clear of the four-cycle minimum of the receiver.
  task automatic hp;
    repeat (10) @(negedge ref_clk);
  endtask
  // The data line never moves at the instant the clock falls, so no false start is seen.
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge ref_clk);
    pull = ~b;
    hp;
    scl = 1'b1;
    hp;
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start;
    hp;
    pull = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    pull = 1'b1;
    hp;
    scl = 1'b0;
  endtask
  task automatic stop;
    repeat (2) @(negedge ref_clk);
    pull = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    pull = 1'b0;
    hp;
  endtask
  task automatic put(input logic [7:0] d, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ok = ~r;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start;
    put({`OPC_DEV_ADDR, 1'b0}, k1);
    put(a, k2);
    put(d, k3);
    stop;
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ok);
    logic k1, k2, k3, r;
    start;
    put({`OPC_DEV_ADDR, 1'b0}, k1);
    put(a, k2);
    start;
    put({`OPC_DEV_ADDR, 1'b1}, k3);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
    bit_io(1'b1, r);
    stop;
    ok = k1 & k2 & k3;
  endtask
  task automatic wr2(input logic [7:0] a, input logic [15:0] d, output logic ok);
    logic k1, k2, k3, k4;
    start;
    put({`OPC_DEV_ADDR, 1'b0}, k1);
    put(a, k2);
    put(d[15:8], k3);
    put(d[7:0], k4);
    stop;
    ok = k1 & k2 & k3 & k4;
  endtask
  // The master acknowledges the first byte so the slave goes on to send the next one.
  task automatic rd2(input logic [7:0] a, output logic [15:0] q, output logic ok);
    logic k1, k2, k3, r;
    start;
    put({`OPC_DEV_ADDR, 1'b0}, k1);
    put(a, k2);
    start;
    put({`OPC_DEV_ADDR, 1'b1}, k3);
    for (int i = 15; i >= 8; i--) bit_io(1'b1, q[i]);
    bit_io(1'b0, r);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
    bit_io(1'b1, r);
    stop;
    ok = k1 & k2 & k3;
  endtask
  task automatic probe(input logic [6:0] dev, output logic ok);
    start;
    put({dev, 1'b0}, ok);
    stop;
  endtask
endmodule // cfg_host

// File: testbench/tb_output_power_control_regs.sv
`timescale 1ns/100ps
`include "opc_params.svh"
module tb_output_power_control_regs;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pd_pin = 1'b0;
  logic int_mclk_tick = 1'b0;
  logic ext_mclk_pin = 1'b0;
  logic scl, pull, sda_oe, ack;
  logic [7:0] q;
  logic [1:0] video_mode;
  logic video_12b_422, primary_out_en, secondary_out_en, video_oe, spdif_oe, i2s_mclk_oe;
  logic green_channel_sync_out_oe, power_down, auto_low_power_en, protection_addr_lsb;
  logic mclk_ext_sel, embedded_timing_code_enable, sample_drop, sample_repeat;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_drop = 0;
  int n_rep = 0;
  wire sda = ~(pull | sda_oe);
  wire [7:0] oes = {video_oe, green_channel_sync_out_oe, spdif_oe, i2s_mclk_oe, power_down,
    primary_out_en, secondary_out_en, video_12b_422};
  wire [7:0] cfg = {auto_low_power_en, protection_addr_lsb, mclk_ext_sel,
    embedded_timing_code_enable, video_mode, 2'h0};

  always #25 ref_clk = ~ref_clk;

  output_power_control_regs uut (.*, .scl_in(scl), .sda_in(sda), .sda_out());
  cfg_host host (.ref_clk, .sda, .scl, .pull);
  ////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, ack);
    chk1(ack, 1'b1);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, q, ack);
    chk1(ack, 1'b1);
    chk8(q, exp);
  endtask
  task automatic w2(input logic [7:0] a, input logic [15:0] d);
    host.wr2(a, d, ack);
    chk1(ack, 1'b1);
  endtask
  task automatic r2(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q2;
    host.rd2(a, q2, ack);
    chk1(ack, 1'b1);
    chk8(q2[15:8], exp[15:8]);
    chk8(q2[7:0], exp[7:0]);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  // Pulses are counted mid-cycle, where the registered outputs have settled.
  always @(negedge ref_clk) begin
    cyc++;
    n_drop += sample_drop;
    n_rep += sample_repeat;
    if (cyc == 40000) begin
      errors++;
      $display("[ERR] %0t run too long", $time);
      end_sim;
    end
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk8(oes, 8'hf4);
    chk8(cfg, 8'h80);
    r(`OPC_ADDR_PORT, 8'h72);
    r(`OPC_ADDR_TRI, 8'h08);
    r(`OPC_ADDR_LPWR, 8'h80);
    for (int m = 0; m < 4; m++) begin
      w(`OPC_ADDR_PORT, {4'h7, m[1:0], 2'h3});
      chk8(oes, {5'h1e, 1'b1, m == 1 || m == 2, m == 3});
      chk8(cfg, {4'h8, m[1:0], 2'h0});
    end
    w(`OPC_ADDR_PORT, 8'h70);
    chk8(oes, 8'hf0);
    for (int i = 0; i < 4; i++) begin
      w(`OPC_ADDR_TRI, 8'h08 | (8'h80 >> i));
      chk8(oes, ~(8'h80 >> i) & 8'hf0);
    end
    r(`OPC_ADDR_TRI, 8'h18);
    w(`OPC_ADDR_TRI, 8'h09);
    chk8(oes, 8'hf8);
    for (int f = 0; f < 4; f++) begin
      w(`OPC_ADDR_TRI, {5'h01, f[1:0], 1'b0});
      pd_pin = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk8(oes, {f < 2, f[0] == 0, f < 2, f < 2, f < 2, 3'h0});
      pd_pin = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk8(oes, 8'hf0);
    end
    // With the low-active setting an idle low pin already means power-down.
    w(`OPC_ADDR_TRI, 8'h00);
    chk8(oes, 8'hf8);
    pd_pin = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk8(oes, 8'hf0);
    w2(`OPC_ADDR_PORT, 16'h7208);
    chk8(oes, 8'hfc);
    r2(`OPC_ADDR_PORT, 16'h7208);
    w(`OPC_ADDR_LPWR, 8'h70);
    chk8(cfg, 8'h70);
    r(`OPC_ADDR_LPWR, 8'h70);
    r(8'h40, 8'h00);
    host.probe(7'h2a, ack);
    chk1(ack, 1'b0);
    n_drop = 0;
    n_rep = 0;
    repeat (4) begin
      int_mclk_tick = 1'b1;
      @(negedge ref_clk);
      int_mclk_tick = 1'b0;
      @(negedge ref_clk);
    end
    repeat (4) @(negedge ref_clk);
    chk1(n_drop != 0, 1'b1);
    chk1(n_rep != 0, 1'b0);
    n_rep = 0;
    repeat (8) begin
      ext_mclk_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      ext_mclk_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
    chk1(n_rep != 0, 1'b1);
    end_sim;
  end
endmodule // tb_output_power_control_regs
